//--- logic/afr_pkg.sv
`default_nettype none
package afr_pkg;
  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_FRAME_LIMIT = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_FRAME_TALLY = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK    = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_AUX_ROUTING = 8'hD0;
  localparam logic [ADDR_W-1:0] OFS_BUF_WORDS   = 8'hE0;

  // reset values
  localparam logic [DATA_W-1:0] RST_WORD    = 32'h0000_0000;
  localparam int                ROUTING_W   = 8;
  localparam logic [ROUTING_W-1:0] RST_ROUTING = 8'h00;

  // routing fields
  localparam int SRC_W            = 3;
  localparam int NUM_SRC          = 8;
  localparam int A_SRC_LSB        = 0;
  localparam int A_STRETCH_BIT    = 3;
  localparam int B_SRC_LSB        = 4;
  localparam int B_STRETCH_BIT    = 7;

  // output b source codes
  localparam int SRC_B_CTR2       = 0;
  localparam int SRC_B_OUT_BIT5   = 1;
  localparam int SRC_B_SAMPLE     = 2;
  localparam int SRC_B_ACTIVE     = 3;
  localparam int SRC_B_FRAME_TMR  = 4;
  localparam int SRC_B_IRQ_CNT    = 5;
  localparam int SRC_B_ZERO       = 6;
  localparam int SRC_B_WAIT_RDY   = 7;

  // output a source codes
  localparam int SRC_A_CTR0       = 0;
  localparam int SRC_A_OUT_BIT4   = 1;
  localparam int SRC_A_TRIG_END   = 2;
  localparam int SRC_A_TRIG_START = 3;
  localparam int SRC_A_THRESH_MAX = 4;
  localparam int SRC_A_ACTIVE     = 5;
  localparam int SRC_A_MSB_DECODE = 6;
  localparam int SRC_A_IRQ        = 7;

  // interrupt status bits
  localparam int IRQ_W         = 2;
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_WRAP_BIT  = 1;

  // pulse stretch timing
  localparam int CLK_PERIOD_NS  = 4;
  localparam int STRETCH_NS     = 100;
  localparam int STRETCH_CYCLES = (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRETCH_CNT_W  = 5;
  localparam logic [STRETCH_CNT_W-1:0] STRETCH_LOAD = STRETCH_CNT_W'(STRETCH_CYCLES - 1);

  // byte-enable merge of a write into a stored word
  function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
                                                  input logic [DATA_W-1:0] new_v,
                                                  input logic [BE_W-1:0]   be);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < BE_W; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return (old_v & ~m) | (new_v & m);
  endfunction
endpackage
`default_nettype wire

//--- logic/afr_aux_if.sv
`timescale 1ns/1ps
`default_nettype none
interface afr_aux_if;
  logic [afr_pkg::SRC_W-1:0]   source;
  logic                        stretch;
  logic [afr_pkg::NUM_SRC-1:0] sources;
  logic                        aux_out;

  modport cfg (output source, output stretch, output sources, input aux_out);
  modport drv (input source, input stretch, input sources, output aux_out);
endinterface
`default_nettype wire

//--- logic/afr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module afr_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // pin in, clean level out
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // three stages, level taken once stages two and three agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_r <= 1'h0;
      s2_r <= 1'h0;
      s3_r <= 1'h0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level_out <= 1'h0;
    end else if (s2_r == s3_r) begin
      level_out <= s3_r;
    end
  end
endmodule
`default_nettype wire

//--- logic/afr_stretch.sv
`timescale 1ns/1ps
`default_nettype none
module afr_stretch (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // routing and output
  afr_aux_if.drv    aux
);
  logic                              sel;
  logic                              sel_d_r;
  logic                              fall;
  logic [afr_pkg::STRETCH_CNT_W-1:0] cnt_r;

  assign sel  = aux.sources[aux.source];
  assign fall = aux.stretch && sel_d_r && !sel;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_d_r <= 1'h0;
    end else begin
      sel_d_r <= sel;
    end
  end

  // hold-off counter after the selected signal falls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (!aux.stretch) begin
      cnt_r <= '0;
    end else if (fall) begin
      cnt_r <= afr_pkg::STRETCH_LOAD;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'h1;
    end
  end

  // registered output, extended only with stretch on
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aux.aux_out <= 1'h0;
    end else begin
      aux.aux_out <= sel || fall || (aux.stretch && cnt_r != '0);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ext_hold_a: assert property (fall && aux.stretch && $stable(aux.stretch)
                               |-> ##1 aux.aux_out [*8])
    else $error("stretched output dropped early");
  pass_thru_a: assert property (!aux.stretch && !$past(aux.stretch)
                                |-> aux.aux_out == $past(sel))
    else $error("unstretched output differs from source");
  ext_end_a: assert property (aux.stretch && cnt_r == 5'h01 && !sel && !fall
                              ##1 !sel |=> !aux.aux_out)
    else $error("stretched output held too long");
  stretch_run_c: cover property (fall ##1 aux.aux_out [*8]);
endmodule
`default_nettype wire

//--- logic/afr_top.sv
// Behaviour
// - while the frame tally equals a nonzero frame limit the match output is high.
// - the frame limit is a 32-bit read-write word, zero at reset, writable per byte lane.
// - the tally counts samples with burst mode off and completed frames with it on.
// - the frame tally is a read-only 32-bit word, zero after reset.
// - the routing register keeps output b fields in bits 7 to 4 and output a in bits 3 to 0.
// - the upper routing byte is ignored and has no effect.
// - with a stretch bit set the selected signal is lengthened by about 100 ns.
// - output b codes select counter 2, bit 5, sample, active, frame timer, irq inc, zero, wait.
// - output a codes select counter 0, bit 4, delay end, start, threshold, active, decode, irq.
// - the buffer word count is a read-only 32-bit word, zero at reset, giving waiting words.
`timescale 1ns/1ps
`default_nettype none
module afr_top (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // register port
  input  wire logic [afr_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [afr_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic [afr_pkg::BE_W-1:0]     reg_be,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [afr_pkg::DATA_W-1:0]   reg_rdata,
  // acquisition events
  input  wire logic                         burst_mode,
  input  wire logic                         acq_arm,
  input  wire logic                         sample_done,
  input  wire logic                         frame_done,
  input  wire logic [afr_pkg::DATA_W-1:0]   buffer_words_in,
  // routing sources
  input  wire logic                         ctr0_out,
  input  wire logic                         ctr2_out,
  input  wire logic                         digital_output_bit4,
  input  wire logic                         digital_output_bit5,
  input  wire logic                         sample_burst_pulse,
  input  wire logic                         sampling_active,
  input  wire logic                         frame_timer_out,
  input  wire logic                         irq_count_inc,
  input  wire logic                         bus_wait_ready_pin,
  input  wire logic                         trig_delay_end,
  input  wire logic                         trig_delay_start,
  input  wire logic                         thresh_count_max,
  input  wire logic                         data_high_decode,
  input  wire logic                         board_irq,
  // results
  output logic                              frame_match,
  output logic                              irq,
  output logic                              aux_output_a,
  output logic                              aux_output_b
);
  logic [afr_pkg::DATA_W-1:0]    frame_limit_value_r;
  logic [afr_pkg::DATA_W-1:0]    frame_limit_value_nxt;
  logic [afr_pkg::DATA_W-1:0]    frame_tally_r;
  logic [afr_pkg::DATA_W-1:0]    frame_tally_nxt;
  logic [afr_pkg::ROUTING_W-1:0] routing_r;
  logic [afr_pkg::DATA_W-1:0]    buffer_word_count_r;
  logic [afr_pkg::IRQ_W-1:0]     irq_status_r;
  logic [afr_pkg::IRQ_W-1:0]     irq_status_nxt;
  logic [afr_pkg::IRQ_W-1:0]     irq_mask_r;
  logic [afr_pkg::IRQ_W-1:0]     irq_events;
  logic [afr_pkg::IRQ_W-1:0]     irq_clear;
  logic [afr_pkg::DATA_W-1:0]    rd_mux;
  logic [afr_pkg::DATA_W-1:0]    routing_merged;
  logic                          count_evt;
  logic                          match_nxt;
  logic                          tally_wrap;
  logic                          bus_wait_ready;
  logic                          wr_limit;
  logic                          wr_routing;
  logic                          wr_status;
  logic                          wr_mask;

  afr_aux_if aux_a ();
  afr_aux_if aux_b ();

  assign wr_limit   = reg_wr && reg_addr == afr_pkg::OFS_FRAME_LIMIT;
  assign wr_routing = reg_wr && reg_addr == afr_pkg::OFS_AUX_ROUTING;
  assign wr_status  = reg_wr && reg_addr == afr_pkg::OFS_IRQ_STATUS;
  assign wr_mask    = reg_wr && reg_addr == afr_pkg::OFS_IRQ_MASK;

  // frame limit, byte-lane writes
  always_comb begin
    frame_limit_value_nxt = frame_limit_value_r;
    if (wr_limit) begin
      frame_limit_value_nxt = afr_pkg::be_merge(frame_limit_value_r, reg_wdata, reg_be);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_limit_value_r <= afr_pkg::RST_WORD;
    end else begin
      frame_limit_value_r <= frame_limit_value_nxt;
    end
  end

  // frame tally
  assign count_evt  = burst_mode ? frame_done : sample_done;
  assign tally_wrap = count_evt && !acq_arm && (&frame_tally_r);

  always_comb begin
    frame_tally_nxt = frame_tally_r;
    if (acq_arm) begin
      frame_tally_nxt = '0;
    end else if (count_evt) begin
      frame_tally_nxt = frame_tally_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_tally_r <= afr_pkg::RST_WORD;
    end else begin
      frame_tally_r <= frame_tally_nxt;
    end
  end

  // limit compare
  assign match_nxt = (frame_limit_value_nxt != '0) && (frame_tally_nxt == frame_limit_value_nxt);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_match <= 1'h0;
    end else begin
      frame_match <= match_nxt;
    end
  end

  // routing register, low byte only
  assign routing_merged = afr_pkg::be_merge({24'h00_0000, routing_r}, reg_wdata, reg_be);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      routing_r <= afr_pkg::RST_ROUTING;
    end else if (wr_routing) begin
      routing_r <= routing_merged[afr_pkg::ROUTING_W-1:0];
    end
  end

  // buffer word count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buffer_word_count_r <= afr_pkg::RST_WORD;
    end else begin
      buffer_word_count_r <= buffer_words_in;
    end
  end

  // interrupt status, set wins over clear
  assign irq_events[afr_pkg::IRQ_MATCH_BIT] = match_nxt && !frame_match;
  assign irq_events[afr_pkg::IRQ_WRAP_BIT]  = tally_wrap;
  assign irq_clear = (wr_status && reg_be[0]) ? reg_wdata[afr_pkg::IRQ_W-1:0] : '0;
  assign irq_status_nxt = (irq_status_r & ~irq_clear) | irq_events;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_mask_r <= '0;
    end else if (wr_mask && reg_be[0]) begin
      irq_mask_r <= reg_wdata[afr_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'h0;
    end else begin
      irq <= |(irq_status_nxt & irq_mask_r);
    end
  end

  // read data, valid the cycle after the strobe only
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      afr_pkg::OFS_FRAME_LIMIT: rd_mux = frame_limit_value_r;
      afr_pkg::OFS_FRAME_TALLY: rd_mux = frame_tally_r;
      afr_pkg::OFS_IRQ_STATUS:  rd_mux[afr_pkg::IRQ_W-1:0] = irq_status_r;
      afr_pkg::OFS_IRQ_MASK:    rd_mux[afr_pkg::IRQ_W-1:0] = irq_mask_r;
      afr_pkg::OFS_AUX_ROUTING: rd_mux[afr_pkg::ROUTING_W-1:0] = routing_r;
      afr_pkg::OFS_BUF_WORDS:   rd_mux = buffer_word_count_r;
      default:                  rd_mux = '0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= '0;
    end
  end

  // wait-ready arrives from the bus pin
  afr_sync u_wait_sync (
    .clock     (clock),
    .rst       (rst),
    .pin_in    (bus_wait_ready_pin),
    .level_out (bus_wait_ready)
  );

  // output a routing
  always_comb begin
    aux_a.sources = '0;
    aux_a.sources[afr_pkg::SRC_A_CTR0]       = ctr0_out;
    aux_a.sources[afr_pkg::SRC_A_OUT_BIT4]   = digital_output_bit4;
    aux_a.sources[afr_pkg::SRC_A_TRIG_END]   = trig_delay_end;
    aux_a.sources[afr_pkg::SRC_A_TRIG_START] = trig_delay_start;
    aux_a.sources[afr_pkg::SRC_A_THRESH_MAX] = thresh_count_max;
    aux_a.sources[afr_pkg::SRC_A_ACTIVE]     = sampling_active;
    aux_a.sources[afr_pkg::SRC_A_MSB_DECODE] = data_high_decode;
    aux_a.sources[afr_pkg::SRC_A_IRQ]        = board_irq;
  end
  assign aux_a.source  = routing_r[afr_pkg::A_SRC_LSB +: afr_pkg::SRC_W];
  assign aux_a.stretch = routing_r[afr_pkg::A_STRETCH_BIT];

  // output b routing
  always_comb begin
    aux_b.sources = '0;
    aux_b.sources[afr_pkg::SRC_B_CTR2]      = ctr2_out;
    aux_b.sources[afr_pkg::SRC_B_OUT_BIT5]  = digital_output_bit5;
    aux_b.sources[afr_pkg::SRC_B_SAMPLE]    = sample_burst_pulse;
    aux_b.sources[afr_pkg::SRC_B_ACTIVE]    = sampling_active;
    aux_b.sources[afr_pkg::SRC_B_FRAME_TMR] = frame_timer_out;
    aux_b.sources[afr_pkg::SRC_B_IRQ_CNT]   = irq_count_inc;
    aux_b.sources[afr_pkg::SRC_B_ZERO]      = 1'h0;
    aux_b.sources[afr_pkg::SRC_B_WAIT_RDY]  = bus_wait_ready;
  end
  assign aux_b.source  = routing_r[afr_pkg::B_SRC_LSB +: afr_pkg::SRC_W];
  assign aux_b.stretch = routing_r[afr_pkg::B_STRETCH_BIT];

  afr_stretch u_stretch_a (
    .clock (clock),
    .rst   (rst),
    .aux   (aux_a)
  );

  afr_stretch u_stretch_b (
    .clock (clock),
    .rst   (rst),
    .aux   (aux_b)
  );

  assign aux_output_a = aux_a.aux_out;
  assign aux_output_b = aux_b.aux_out;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  limit_match_a: assert property (frame_match == ((frame_limit_value_r != '0)
                                  && (frame_tally_r == frame_limit_value_r)))
    else $error("match output disagrees with compare");
  limit_write_a: assert property (wr_limit && reg_be == 4'hF
                                  |=> frame_limit_value_r == $past(reg_wdata))
    else $error("frame limit full write lost");
  limit_lane_a: assert property (wr_limit && !reg_be[3]
                                 |=> frame_limit_value_r[31:24] == $past(frame_limit_value_r[31:24]))
    else $error("frame limit disabled lane changed");
  tally_sample_a: assert property (!burst_mode && sample_done && !acq_arm
                                   |=> frame_tally_r == $past(frame_tally_r) + 32'h0000_0001)
    else $error("sample not counted");
  tally_frame_a: assert property (burst_mode && !frame_done && !acq_arm
                                  |=> frame_tally_r == $past(frame_tally_r))
    else $error("burst tally moved without frame");
  tally_read_a: assert property (reg_rd && reg_addr == afr_pkg::OFS_FRAME_TALLY
                                 |=> reg_rdata == $past(frame_tally_r))
    else $error("tally read wrong");
  tally_arm_a: assert property (acq_arm |=> frame_tally_r == '0)
    else $error("arm did not clear tally");
  route_upper_a: assert property (wr_routing && !reg_be[0] |=> $stable(routing_r))
    else $error("upper routing byte had effect");
  route_sel_a: assert property (routing_r[6:4] == 3'h6 && $stable(routing_r) && !aux_b.stretch
                                |=> !aux_output_b)
    else $error("zero source not zero");
  route_a_sel_a: assert property (routing_r[3:0] == 4'h3 ##1 routing_r[3:0] == 4'h3
                                  |-> aux_output_a == $past(trig_delay_start))
    else $error("output a start pulse routing wrong");
  bufcount_a: assert property (reg_rd && reg_addr == afr_pkg::OFS_BUF_WORDS
                               |=> reg_rdata == $past(buffer_word_count_r))
    else $error("buffer count read wrong");
  status_set_a: assert property (irq_events[0] |=> irq_status_r[0])
    else $error("match event lost");
  status_clr_a: assert property (wr_status && reg_be[0] && reg_wdata[0] && !irq_events[0]
                                 |=> !irq_status_r[0])
    else $error("match status not cleared");
  irq_level_a: assert property ($stable(irq_mask_r)
                                |-> irq == |(irq_status_r & irq_mask_r))
    else $error("irq level disagrees with status");

  match_seen_c: cover property (!frame_match ##1 frame_match);
  irq_seen_c: cover property (irq);
  arm_clear_c: cover property (frame_match ##1 acq_arm);
endmodule
`default_nettype wire

//--- dv/afr_host.sv
`timescale 1ns/1ps
`default_nettype none
module afr_host (
  // clock
  input  wire logic                       clock,
  // register port
  output logic      [afr_pkg::ADDR_W-1:0] reg_addr,
  output logic      [afr_pkg::DATA_W-1:0] reg_wdata,
  output logic      [afr_pkg::BE_W-1:0]   reg_be,
  output logic                            reg_wr,
  output logic                            reg_rd,
  input  wire logic [afr_pkg::DATA_W-1:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_be = 4'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end

  // one-cycle write; released address and data lines are inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_be <= be;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // one-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // limit only programmed within one to the upper bound
  task automatic set_limit(input logic [31:0] v);
    if (v >= 32'h0000_0001 && v <= 32'h8000_0000) begin
      wr(afr_pkg::OFS_FRAME_LIMIT, v, 4'hF);
    end
  endtask
endmodule
`default_nettype wire

//--- dv/afr_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module afr_top_bench;
  logic        clock;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [3:0]  reg_be;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        burst_mode;
  logic [2:0]  ev;
  logic [31:0] buf_words;
  logic [7:0]  src_a;
  logic [7:0]  src_b;
  logic        frame_match;
  logic        irq;
  logic        aux_a;
  logic        aux_b;
  int          fails;
  int          check_count;

  afr_host host_u (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  afr_top dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .burst_mode(burst_mode), .acq_arm(ev[2]), .sample_done(ev[0]), .frame_done(ev[1]),
    .buffer_words_in(buf_words), .ctr0_out(src_a[0]), .ctr2_out(src_b[0]),
    .digital_output_bit4(src_a[1]), .digital_output_bit5(src_b[1]),
    .sample_burst_pulse(src_b[2]), .sampling_active(src_a[5] | src_b[3]),
    .frame_timer_out(src_b[4]), .irq_count_inc(src_b[5]), .bus_wait_ready_pin(src_b[7]),
    .trig_delay_end(src_a[2]), .trig_delay_start(src_a[3]), .thresh_count_max(src_a[4]),
    .data_high_decode(src_a[6]), .board_irq(src_a[7]), .frame_match(frame_match),
    .irq(irq), .aux_output_a(aux_a), .aux_output_b(aux_b));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host_u.rd(a, d);
    chk(name, exp, d);
  endtask

  task automatic pulse(input logic [2:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 3'h0;
  endtask

  task automatic t_reset;
    rchk("limit_rst", 8'h2C, 32'h0);
    rchk("tally_rst", 8'h30, 32'h0);
    rchk("routing_rst", 8'hD0, 32'h0);
    rchk("bufcount_rst", 8'hE0, 32'h0);
    rchk("unmapped", 8'h10, 32'h0);
  endtask

  task automatic t_limit;
    host_u.wr(8'h2C, 32'h1234_5678, 4'hF);
    rchk("limit_full", 8'h2C, 32'h1234_5678);
    host_u.wr(8'h2C, 32'h0000_00AA, 4'h1);
    host_u.wr(8'h2C, 32'hABCD_0000, 4'hC);
    rchk("limit_lanes", 8'h2C, 32'hABCD_56AA);
    host_u.wr(8'h30, 32'hFFFF_FFFF, 4'hF);
    rchk("tally_ro", 8'h30, 32'h0);
  endtask

  task automatic t_count;
    host_u.set_limit(32'h3);
    host_u.wr(8'h44, 32'h1, 4'h1);
    pulse(3'h4);
    pulse(3'h2);
    pulse(3'h1);
    pulse(3'h1);
    @(negedge clock);
    chk("match_early", 32'h0, frame_match);
    pulse(3'h1);
    @(negedge clock);
    chk("match_hit", 32'h1, frame_match);
    rchk("tally_samples", 8'h30, 32'h3);
    chk("irq_on", 32'h1, irq);
    rchk("status_set", 8'h40, 32'h1);
    host_u.wr(8'h40, 32'h1, 4'h1);
    @(negedge clock);
    chk("irq_clr", 32'h0, irq);
    rchk("status_clr", 8'h40, 32'h0);
    @(posedge clock);
    burst_mode <= 1'h1;
    pulse(3'h4);
    @(negedge clock);
    chk("match_arm", 32'h0, frame_match);
    rchk("tally_arm", 8'h30, 32'h0);
    pulse(3'h1);
    pulse(3'h2);
    pulse(3'h2);
    rchk("tally_frames", 8'h30, 32'h2);
    pulse(3'h2);
    @(negedge clock);
    chk("match_burst", 32'h1, frame_match);
  endtask

  task automatic route_one(input logic [7:0] cfg, input logic a_side, input int k);
    logic [7:0] one;
    one = 8'h01 << k;
    host_u.wr(8'hD0, {24'h0, cfg}, 4'hF);
    for (int ph = 0; ph < 2; ph++) begin
      @(posedge clock);
      src_a <= a_side ? (ph == 0 ? one : ~one) : 8'h00;
      src_b <= a_side ? 8'h00 : (ph == 0 ? one : ~one);
      repeat (6) @(negedge clock);
      if (a_side) begin
        chk("aux_a_route", (ph == 0) ? 32'h1 : 32'h0, aux_a);
        chk("aux_b_zero", 32'h0, aux_b);
      end else begin
        chk("aux_b_route", (ph == 0 && k != 6) ? 32'h1 : 32'h0, aux_b);
      end
    end
  endtask

  task automatic t_route;
    for (int k = 0; k < 8; k++) begin
      route_one(8'h60 | 8'(k), 1'h1, k);
      route_one(8'(k << 4), 1'h0, k);
    end
    host_u.wr(8'hD0, 32'hFFFF_FF5A, 4'hF);
    rchk("routing_upper", 8'hD0, 32'h0000_005A);
    host_u.wr(8'hD0, 32'h0000_FF00, 4'hE);
    rchk("routing_hi_lane", 8'hD0, 32'h0000_005A);
  endtask

  task automatic stretch_one(input logic [7:0] cfg, input logic [31:0] exp);
    logic [31:0] n;
    n = 32'h0;
    host_u.wr(8'hD0, {24'h0, cfg}, 4'hF);
    @(posedge clock);
    src_a <= 8'h01;
    @(posedge clock);
    src_a <= 8'h00;
    repeat (40) @(negedge clock) if (aux_a === 1'h1) n++;
    chk("stretch_len", exp, n);
  endtask

  task automatic t_stretch;
    @(posedge clock);
    src_b <= 8'h00;
    stretch_one(8'h00, 32'h1);
    stretch_one(8'h08, 32'h1A);
  endtask

  task automatic t_buf;
    @(posedge clock);
    buf_words <= 32'h0000_1234;
    rchk("bufcount", 8'hE0, 32'h0000_1234);
    host_u.wr(8'hE0, 32'hFFFF_FFFF, 4'hF);
    rchk("bufcount_ro", 8'hE0, 32'h0000_1234);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(4 * 20000);
    fails++;
    print_verdict();
  end

  initial begin
    fails = 0;
    check_count = 0;
    rst = 1'h1;
    burst_mode = 1'h0;
    ev = 3'h0;
    buf_words = 32'h0;
    src_a = 8'h00;
    src_b = 8'h00;
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    t_reset();
    t_limit();
    t_count();
    t_route();
    t_stretch();
    t_buf();
    print_verdict();
  end
endmodule
`default_nettype wire
